// >>> logic/afr_pkg.sv
// Shared constants for the amplifier fault reporting ends
package afr_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS   = 10;
  // Overload protection count period in microseconds
  localparam int unsigned OVERLOAD_US     = 1250;
  localparam int unsigned OVERLOAD_CYCLES =
    (OVERLOAD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least wait before reset after overload shutdown, in ms
  localparam int unsigned RECOVER_MS      = 1000;
  localparam int unsigned RECOVER_CYCLES  =
    (RECOVER_MS * 1000 / CLK_PERIOD_NS) * 1000;
  // Reset pulse width driven by the controller
  localparam int unsigned RESET_PULSE_CYCLES = 16;

  // ==========================================================
  // Flag encoding, active-low pins (shutdown, warning)
  // ==========================================================
  localparam logic [1:0] FLAGS_ERR_ALL   = 2'h0;
  localparam logic [1:0] FLAGS_SHUTDOWN  = 2'h1;
  localparam logic [1:0] FLAGS_WARN_ONLY = 2'h2;
  localparam logic [1:0] FLAGS_NORMAL    = 2'h3;

  // Controller view of the device
  typedef enum logic [3:0] {
    AFR_HST_RUN   = 4'h1,
    AFR_HST_WAIT  = 4'h2,
    AFR_HST_PULSE = 4'h4,
    AFR_HST_HOLD  = 4'h8
  } afr_hst_state_t;

endpackage

// >>> logic/afr_if.sv
// Status and reset pins between power stage and controller
`timescale 1ns/1ps
interface afr_if;
  // Open-drain flags, enable low while device pulls pin low
  logic shutdown_flag_n_o;
  logic shutdown_flag_n_oe_n;
  logic thermal_warning_n_o;
  logic thermal_warning_n_oe_n;
  logic shutdown_flag_n;
  logic thermal_warning_n;
  // Reset pin driven by controller, active low
  logic reset_n;

  assign shutdown_flag_n   = shutdown_flag_n_oe_n ? 1'b1 : shutdown_flag_n_o;
  assign thermal_warning_n =
    thermal_warning_n_oe_n ? 1'b1 : thermal_warning_n_o;

  modport device (
    output shutdown_flag_n_o,
    output shutdown_flag_n_oe_n,
    output thermal_warning_n_o,
    output thermal_warning_n_oe_n,
    input  reset_n
  );

  modport host (
    input  shutdown_flag_n,
    input  thermal_warning_n,
    output reset_n
  );
endinterface

// >>> logic/afr_device.sv
// Power stage fault handling and status flag driver
//
// Summary of operation
// - Outputs Hi-Z while any supply undervoltage
// - Both flags are active-low open-drain pins
// - Any shutdown fault pulls shutdown flag low
// - Warning flag low while above warning level
// - Flag pair encodes fault class
// - Reset low forces both flags high
// - Fault immediately sets Hi-Z and shutdown flag
// - Non-overload faults recover automatically
// - Controller resets overload no sooner than 1s
// - Controller may hold reset during ramp-up
// - Controller holds reset during power-down
// - Controller watches warning, reduces volume
// - Reset low forces all outputs Hi-Z
// - Reset rising edge clears latched overload
// - Overload latched after persistent overcurrent
// - Thermal error shuts down the stage
`timescale 1ns/1ps
module afr_device #(
  parameter int unsigned OVERLOAD_CYCLES = afr_pkg::OVERLOAD_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Analog detector levels
  input  wire logic gate_drive_supply_low,
  input  wire logic common_supply_low,
  input  wire logic overcurrent,
  input  wire logic thermal_warning,
  input  wire logic thermal_error,
  // Power stage control
  output logic      stage_hiz,
  output logic      overload_fault,
  output logic      undervoltage_fault,
  // Status pins
  afr_if.device     pins
);

  localparam int CW = $clog2(OVERLOAD_CYCLES + 1);
  localparam int NS = 6;

  // Positions of the detector and pin inputs in each sync word
  localparam int IX_GATE_UV = 0;
  localparam int IX_COM_UV  = 1;
  localparam int IX_OC      = 2;
  localparam int IX_WARN    = 3;
  localparam int IX_ERR     = 4;
  localparam int IX_RST     = 5;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [NS-1:0] lvl;
    logic [CW-1:0] oc_cnt;
    logic          ovl;
    logic          uvf;
    logic          hiz;
    logic          shut_low;
    logic          warn_low;
  } afr_dev_state_t;

  afr_dev_state_t st_reg;
  afr_dev_state_t st_next;

  logic [NS-1:0] raw;
  logic [NS-1:0] agree;
  logic          uv;
  logic          hot;
  logic          rst_lvl;
  logic          rst_rise;
  logic          oc_done;
  logic          fault;
  logic [1:0]    flags_pin;

  // ==========================================================
  // Input settling
  // ==========================================================
  // Stages 2 and 3 agreeing make a new level, else the old one holds
  function automatic logic settle(
    input logic stage2,
    input logic stage3,
    input logic held
  );
    logic lvl_out;
    lvl_out = held;
    if (stage2 == stage3) begin
      lvl_out = stage3;
    end
    return lvl_out;
  endfunction

  // ==========================================================
  // Flag pair encoding
  // ==========================================================
  // Pin levels {shutdown, warning}; a low reset releases both
  function automatic logic [1:0] flag_pins(
    input logic shut,
    input logic warn,
    input logic run
  );
    logic [1:0] pair;
    pair = afr_pkg::FLAGS_NORMAL;
    if (!run) begin
      pair = afr_pkg::FLAGS_NORMAL;
    end else if (shut && warn) begin
      pair = afr_pkg::FLAGS_ERR_ALL;
    end else if (shut) begin
      pair = afr_pkg::FLAGS_SHUTDOWN;
    end else if (warn) begin
      pair = afr_pkg::FLAGS_WARN_ONLY;
    end
    return pair;
  endfunction

  // Raw input order: reset, error, warning, overcurrent, supplies
  assign raw = {pins.reset_n, thermal_error, thermal_warning, overcurrent,
                common_supply_low, gate_drive_supply_low};

  // ==========================================================
  // Three-stage sync, level changes when stages 2 and 3 agree
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_filt
      assign agree[g] = settle(st_reg.s2[g], st_reg.s3[g], st_reg.lvl[g]);
    end
  endgenerate

  // ==========================================================
  // Decoded levels
  // ==========================================================
  assign rst_lvl  = st_reg.lvl[IX_RST];
  assign rst_rise = agree[IX_RST] & ~rst_lvl;
  assign uv       = st_reg.lvl[IX_GATE_UV] | st_reg.lvl[IX_COM_UV];
  assign hot      = st_reg.lvl[IX_WARN] | st_reg.lvl[IX_ERR];
  assign oc_done  = (st_reg.oc_cnt == CW'(OVERLOAD_CYCLES - 1));

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_next = st_reg;

    // Synchroniser shift and settled levels
    st_next.s1  = raw;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    st_next.lvl = agree;

    // Reset edge frees the latch; a new overload below still wins
    if (rst_rise) begin
      st_next.ovl = 1'b0;
    end

    // Overload persistence counter, idle while latched
    if (st_reg.lvl[IX_OC] && !st_reg.ovl) begin
      if (oc_done) begin
        st_next.ovl    = 1'b1;
        st_next.oc_cnt = '0;
      end else begin
        st_next.oc_cnt = st_reg.oc_cnt + CW'(1);
      end
    end else begin
      st_next.oc_cnt = '0;
    end

    // Any shutdown fault, overload as of this edge
    fault       = uv | st_reg.lvl[IX_ERR] | st_next.ovl;
    st_next.uvf = agree[IX_GATE_UV] | agree[IX_COM_UV];

    // Non-overload faults release one cycle after their settled level clears
    st_next.hiz = fault | ~agree[IX_RST];

    // Flags stay released while the filtered reset is low
    flags_pin        = flag_pins(fault, hot, agree[IX_RST]);
    st_next.shut_low = ~flags_pin[1];
    st_next.warn_low = ~flags_pin[0];
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg     <= '0;
      st_reg.hiz <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign stage_hiz          = st_reg.hiz;
  assign overload_fault     = st_reg.ovl;
  assign undervoltage_fault = st_reg.uvf;
  // Open-drain: drive value fixed low, enable carries the level
  assign pins.shutdown_flag_n_o       = 1'b0;
  assign pins.shutdown_flag_n_oe_n    = ~st_reg.shut_low;
  assign pins.thermal_warning_n_o     = 1'b0;
  assign pins.thermal_warning_n_oe_n  = ~st_reg.warn_low;

endmodule // afr_device

// >>> logic/afr_host.sv
// Controller end: watches flags and recovers from overload
`timescale 1ns/1ps
module afr_host #(
  parameter int unsigned RECOVER_CYCLES = afr_pkg::RECOVER_CYCLES,
  parameter int unsigned PULSE_CYCLES   = afr_pkg::RESET_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // User side
  input  wire logic hold_reset,
  output logic      fault_active,
  output logic      warning_active,
  output logic      reduce_volume,
  output logic      recovering,
  // Status pins
  afr_if.host       pins
);

  localparam int CW = $clog2(RECOVER_CYCLES + PULSE_CYCLES + 1);

  typedef struct packed {
    logic [1:0]             s1;
    logic [1:0]             s2;
    logic [1:0]             s3;
    logic [1:0]             lvl;
    logic [CW-1:0]          cnt;
    afr_pkg::afr_hst_state_t st;
    logic                   rst_n;
  } afr_hst_t;

  afr_hst_t r_reg;
  afr_hst_t r_next;
  logic [1:0] agree;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      assign agree[g] = (r_reg.s2[g] == r_reg.s3[g]) ? r_reg.s3[g]
                                                     : r_reg.lvl[g];
    end
  endgenerate

  always_comb begin
    r_next     = r_reg;
    r_next.s1  = {pins.thermal_warning_n, pins.shutdown_flag_n};
    r_next.s2  = r_reg.s1;
    r_next.s3  = r_reg.s2;
    r_next.lvl = agree;
    r_next.rst_n = 1'b1;
    case (r_reg.st)
      afr_pkg::AFR_HST_HOLD: begin
        r_next.rst_n = 1'b0;
        if (!hold_reset) r_next.st = afr_pkg::AFR_HST_RUN;
      end
      afr_pkg::AFR_HST_RUN: begin
        r_next.cnt = '0;
        if (hold_reset) begin
          r_next.st    = afr_pkg::AFR_HST_HOLD;
          r_next.rst_n = 1'b0;
        end else if ({r_reg.lvl[0], r_reg.lvl[1]} ==
                     afr_pkg::FLAGS_SHUTDOWN) begin
          r_next.st = afr_pkg::AFR_HST_WAIT;
        end
      end
      afr_pkg::AFR_HST_WAIT: begin
        if (r_reg.lvl[0]) begin
          r_next.st = afr_pkg::AFR_HST_RUN;
        end else if (r_reg.cnt == CW'(RECOVER_CYCLES - 1)) begin
          r_next.st  = afr_pkg::AFR_HST_PULSE;
          r_next.cnt = '0;
          r_next.rst_n = 1'b0;
        end else begin
          r_next.cnt = r_reg.cnt + CW'(1);
        end
      end
      afr_pkg::AFR_HST_PULSE: begin
        r_next.rst_n = 1'b0;
        if (r_reg.cnt == CW'(PULSE_CYCLES - 1)) begin
          r_next.st    = afr_pkg::AFR_HST_RUN;
          r_next.rst_n = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt + CW'(1);
        end
      end
      default: r_next.st = afr_pkg::AFR_HST_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg       <= '0;
      r_reg.s1    <= 2'h3;
      r_reg.s2    <= 2'h3;
      r_reg.s3    <= 2'h3;
      r_reg.lvl   <= 2'h3;
      r_reg.st    <= afr_pkg::AFR_HST_HOLD;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pins.reset_n     = r_reg.rst_n;
  assign fault_active     = ~r_reg.lvl[0];
  assign warning_active   = ~r_reg.lvl[1];
  assign reduce_volume    = ~r_reg.lvl[1];
  assign recovering       = (r_reg.st == afr_pkg::AFR_HST_WAIT) |
                            (r_reg.st == afr_pkg::AFR_HST_PULSE);

endmodule // afr_host

// >>> test/afr_chk.sv
// Pin-level assertions across the device and controller ends
`timescale 1ns/1ps
module afr_chk #(
  parameter int unsigned RECOVER_CYCLES = 50
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Status pins
  input wire logic shutdown_flag_n_o,
  input wire logic thermal_warning_n_o,
  input wire logic shutdown_flag_n,
  input wire logic thermal_warning_n,
  input wire logic reset_n
);
  // ==========================================================
  // Overload wait counter
  // ==========================================================
  int unsigned wait_reg;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b) wait_reg <= 0;
    else if (!shutdown_flag_n && thermal_warning_n && reset_n)
      wait_reg <= wait_reg + 1;
    else wait_reg <= 0;

  // ==========================================================
  // Properties
  // ==========================================================
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_held; !reset_n [*7]; endsequence
  sequence s_pulse; !reset_n [*4] ##1 reset_n; endsequence

  a_shut_drive_low: assert property (!shutdown_flag_n_o)
    else $error("shutdown drive value high");
  a_warn_drive_low: assert property (!thermal_warning_n_o)
    else $error("warning drive value high");
  a_held_flags_high: assert property (s_held |->
    shutdown_flag_n && thermal_warning_n)
    else $error("flag low while reset held");
  a_held_flags_steady: assert property (s_held ##1 !reset_n |->
    $stable(shutdown_flag_n) && $stable(thermal_warning_n))
    else $error("flag moved while reset held");
  a_shut_release: assert property ($fell(reset_n) |->
    ##[1:7] shutdown_flag_n)
    else $error("shutdown flag not released by reset");
  a_warn_release: assert property ($fell(reset_n) |->
    ##[1:7] thermal_warning_n)
    else $error("warning flag not released by reset");
  a_pulse_shape: assert property ($fell(reset_n) ##0 !shutdown_flag_n
    |-> s_pulse)
    else $error("recovery pulse has wrong width");
  a_no_early_reset: assert property ($fell(reset_n) &&
    $past(!shutdown_flag_n && thermal_warning_n) |->
    $past(wait_reg) >= RECOVER_CYCLES)
    else $error("overload reset issued too early");
endmodule // afr_chk

// >>> test/tb.sv
// Bench joining the device and controller ends
`timescale 1ns/1ps
module tb;
  logic       sys_clk = 0;
  logic       rst_b = 0;
  logic       gds = 0, cms = 0, oc = 0, tw = 0, te = 0, hold = 0;
  logic       hiz, ovl, uvf, fa, wa, rv, rec;
  logic [1:0] fl;
  int         err_total = 0;
  int         total_checks = 0;
  int         cyc_cnt = 0;

  afr_if pins_if();
  assign fl = {pins_if.shutdown_flag_n, pins_if.thermal_warning_n};
  afr_device #(.OVERLOAD_CYCLES(20)) u_afr_device (.sys_clk(sys_clk),
    .rst_b(rst_b), .gate_drive_supply_low(gds), .common_supply_low(cms),
    .overcurrent(oc), .thermal_warning(tw), .thermal_error(te),
    .stage_hiz(hiz), .overload_fault(ovl), .undervoltage_fault(uvf),
    .pins(pins_if.device));
  afr_host #(.RECOVER_CYCLES(50), .PULSE_CYCLES(4)) u_afr_host (
    .sys_clk(sys_clk), .rst_b(rst_b), .hold_reset(hold),
    .fault_active(fa), .warning_active(wa), .reduce_volume(rv),
    .recovering(rec), .pins(pins_if.host));
  afr_chk #(.RECOVER_CYCLES(50)) u_afr_chk (.sys_clk(sys_clk),
    .rst_b(rst_b), .shutdown_flag_n_o(pins_if.shutdown_flag_n_o),
    .thermal_warning_n_o(pins_if.thermal_warning_n_o),
    .shutdown_flag_n(pins_if.shutdown_flag_n),
    .thermal_warning_n(pins_if.thermal_warning_n),
    .reset_n(pins_if.reset_n));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [1:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_uv;
    for (int i = 0; i < 2; i++) begin
      {gds, cms} = i ? 2'h2 : 2'h1;
      cyc(10);
      chk("uv_stage", 2'h3, {hiz, uvf});
      chk("uv_flags", 2'h1, fl);
      chk("uv_host", 2'h2, {fa, wa});
      {gds, cms} = 2'h0;
      cyc(6);
      chk("uv_back", 2'h0, {hiz, uvf});
      chk("uv_bflags", 2'h3, fl);
    end
    $display("done uv");
  endtask
  task automatic t_warn;
    tw = 1;
    cyc(10);
    chk("warn_flags", 2'h2, fl);
    chk("warn_host", 2'h1, {hiz, rv});
    tw = 0;
    cyc(6);
    chk("warn_off", 2'h3, fl);
    $display("done warn");
  endtask
  task automatic t_err;
    {tw, te} = 2'h3;
    cyc(6);
    chk("err_flags", 2'h0, fl);
    cyc(80);
    chk("err_wait", 2'h1, {rec, hiz});
    {tw, te} = 2'h0;
    cyc(8);
    chk("err_back", 2'h1, {hiz, fl[1]});
    $display("done err");
  endtask
  task automatic t_ovl;
    oc = 1;
    cyc(10);
    oc = 0;
    cyc(6);
    chk("ovl_short", 2'h0, {ovl, hiz});
    oc = 1;
    cyc(30);
    oc = 0;
    chk("ovl_set", 2'h3, {ovl, hiz});
    chk("ovl_flags", 2'h1, fl);
    cyc(20);
    chk("ovl_latch", 2'h3, {ovl, rec});
    for (int n = 0; n < 300 && ovl !== 1'b0; n++) cyc(1);
    cyc(8);
    chk("ovl_free", 2'h0, {ovl, hiz});
    chk("ovl_fflags", 2'h3, fl);
    $display("done ovl");
  endtask
  task automatic t_hold;
    hold = 1;
    cyc(10);
    chk("hold_stage", 2'h1, {ovl, hiz});
    te = 1;
    cyc(8);
    chk("hold_flags", 2'h3, fl);
    hold = 0;
    cyc(10);
    chk("hold_rel", 2'h0, fl);
    te = 0;
    cyc(8);
    chk("hold_back", 2'h3, fl);
    $display("done hold");
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    rst_b = 1;
    cyc(10);
    chk("idle_flags", 2'h3, fl);
    chk("idle_stage", 2'h0, {hiz, ovl});
    t_uv();
    t_warn();
    t_err();
    t_ovl();
    t_hold();
    stop_test();
  end
endmodule // tb
